// ===== rtl/fspa_top.sv
// Frame and sync pulse alignment for all timing channels and outputs
`include "fspa_regs.svh"
module fspa_top
  import fspa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [`FSPA_NUM_REF-1:0] ref_in_i,
  input wire fspa_chan_cfg_type chan_cfg_i [`FSPA_NUM_CHAN],
  input wire fspa_out_cfg_type out_cfg_i [`FSPA_NUM_OUT],
  output logic [`FSPA_NUM_OUT-1:0] out_o,
  output fspa_chan_stat_type chan_stat_o [`FSPA_NUM_CHAN]
);

  // Edge of a level seen as previous and current sample
  function automatic logic rise(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction : rise

  // Selected pulse length in output clock periods: 1, 2, 4 or 8
  function automatic logic [`FSPA_DIV_W-1:0] pulse_len(input logic [`FSPA_WIDTH_SEL_W-1:0] sel);
    return `FSPA_PULSE_BASE << sel;
  endfunction : pulse_len

  // Divider clamped to its smallest usable value
  function automatic logic [`FSPA_DIV_W-1:0] clamp_div(input logic [`FSPA_DIV_W-1:0] val,
                                                     input logic [`FSPA_DIV_W-1:0] least);
    return (val < least) ? least : val;
  endfunction : clamp_div

  logic [`FSPA_NUM_REF-1:0] ref_sync;
  logic [`FSPA_NUM_CHAN-1:0] ch_clk;
  logic [`FSPA_NUM_CHAN-1:0] ch_pulse;

  // Every reference pin crosses into the core clock before use
  fspa_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(ref_in_i),
    .sync_o(ref_sync)
  );

  // One alignment channel per timing channel
  for (genvar c = 0; c < `FSPA_NUM_CHAN; c++) begin : g_chan
    fspa_chan_cfg_type cfg;
    fspa_state_type state_q;
    fspa_state_type state_d;
    logic ref_lvl;
    logic pulse_lvl;
    logic ref_prev_q;
    logic pulse_prev_q;
    logic clk_rise;
    logic pulse_edge;
    logic align_now;
    logic in_phase;
    logic [`FSPA_DIV_W-1:0] div_eff;
    logic [`FSPA_DIV_W-1:0] frame_eff;
    logic [`FSPA_DIV_W-1:0] width_req;
    logic [`FSPA_DIV_W-1:0] width_eff;
    logic [`FSPA_DIV_W-1:0] div_cnt_q;
    logic [`FSPA_DIV_W-1:0] div_cnt_d;
    logic [`FSPA_DIV_W-1:0] frame_cnt_q;
    logic [`FSPA_DIV_W-1:0] frame_cnt_d;
    logic div_last;
    logic frame_last;

    assign cfg = chan_cfg_i[c];

    // Any input may serve as the associated clock or as the pulse
    assign ref_lvl = ref_sync[cfg.clk_sel];
    assign pulse_lvl = ref_sync[cfg.pulse_sel];

    // Edge detection on synchronised levels only
    assign clk_rise = rise(ref_prev_q, ref_lvl);
    assign pulse_edge = cfg.fall_edge ? rise(pulse_lvl, pulse_prev_q) : rise(pulse_prev_q, pulse_lvl);

    // Divider ratios; the frame counts whole output clocks, so ratios stay integer
    assign div_eff = clamp_div(cfg.channel_master_divider, `FSPA_MIN_CLK_DIV);
    assign frame_eff = clamp_div(cfg.frame_div, `FSPA_MIN_FRAME_DIV);
    assign div_last = (div_cnt_q >= div_eff - `FSPA_PULSE_BASE);
    assign frame_last = (frame_cnt_q >= frame_eff - `FSPA_PULSE_BASE);

    // Pulse width kept below the frame period so the pulse always returns low
    assign width_req = pulse_len(cfg.width_sel);
    assign width_eff = (width_req >= frame_eff) ? frame_eff - `FSPA_PULSE_BASE : width_req;

    // Alignment event: reference edge after pulse (frame) or pulse edge (sync)
    assign align_now = cfg.channel_pulse_align_enable &
                       ((state_q == FSPA_ST_ARM && clk_rise) ||
                        (state_q == FSPA_ST_WAIT && cfg.sync_mode && pulse_edge));

    // Already in phase means the counters would wrap at this very event (frame) or already sit at zero (sync)
    assign in_phase = cfg.sync_mode ? (div_cnt_q == `FSPA_CNT_RST && frame_cnt_q == `FSPA_CNT_RST)
                                    : (div_last && frame_last);

    // Sequencer next state; disabling alignment drops any pending arm
    always_comb begin
      state_d = state_q;
      unique case (state_q)
        FSPA_ST_WAIT: begin
          if (cfg.channel_pulse_align_enable && !cfg.sync_mode && pulse_edge) begin
            state_d = FSPA_ST_ARM;
          end
        end
        FSPA_ST_ARM: begin
          if (!cfg.channel_pulse_align_enable || cfg.sync_mode || clk_rise) begin
            state_d = FSPA_ST_WAIT;
          end
        end
        default: begin
          state_d = FSPA_ST_WAIT;
        end
      endcase
    end

    // Counters run on associated reference edges and restart on alignment
    always_comb begin
      div_cnt_d = div_cnt_q;
      frame_cnt_d = frame_cnt_q;
      if (align_now) begin
        div_cnt_d = `FSPA_CNT_RST;
        frame_cnt_d = `FSPA_CNT_RST;
      end else if (clk_rise) begin
        div_cnt_d = div_last ? `FSPA_CNT_RST : div_cnt_q + `FSPA_PULSE_BASE;
        if (div_last) begin
          frame_cnt_d = frame_last ? `FSPA_CNT_RST : frame_cnt_q + `FSPA_PULSE_BASE;
        end
      end
    end

    // Output clock high for the first half of each divider period
    assign ch_clk[c] = (div_cnt_q < (div_eff >> 1));
    // Output frame or sync pulse for the chosen width at frame start
    assign ch_pulse[c] = (frame_cnt_q < width_eff);

    // Sample history and sequencer state
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        state_q <= FSPA_ST_WAIT;
        ref_prev_q <= 1'b0;
        pulse_prev_q <= 1'b0;
      end else begin
        state_q <= state_d;
        ref_prev_q <= ref_lvl;
        pulse_prev_q <= pulse_lvl;
      end
    end

    // Divider counters
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        div_cnt_q <= `FSPA_CNT_RST;
        frame_cnt_q <= `FSPA_CNT_RST;
      end else begin
        div_cnt_q <= div_cnt_d;
        frame_cnt_q <= frame_cnt_d;
      end
    end

    // Channel status; align flag clears only when alignment is switched off
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        chan_stat_o[c] <= '0;
      end else begin
        chan_stat_o[c].armed <= (state_d == FSPA_ST_ARM);
        chan_stat_o[c].rate_err <= (cfg.rate > FSPA_RATE_8KHZ);
        if (align_now) begin
          chan_stat_o[c].align_seen <= 1'b1;
          chan_stat_o[c].phase_ok <= in_phase;
        end else if (!cfg.channel_pulse_align_enable) begin
          chan_stat_o[c].align_seen <= 1'b0;
          chan_stat_o[c].phase_ok <= 1'b0;
        end
      end
    end
  end

  // Output stage: each output carries a channel's clock or its pulse
  for (genvar o = 0; o < `FSPA_NUM_OUT; o++) begin : g_out
    logic out_d;

    assign out_d = out_cfg_i[o].pulse_role ? ch_pulse[out_cfg_i[o].chan] : ch_clk[out_cfg_i[o].chan];

    // Registered so every pin comes straight from a flop
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        out_o[o] <= 1'b0;
      end else begin
        out_o[o] <= out_d;
      end
    end
  end

endmodule : fspa_top

// ===== rtl/fspa_regs.svh
// Sizes, field widths and reset values of the frame and sync pulse alignment block
`ifndef FSPA_REGS_SVH
`define FSPA_REGS_SVH

`define FSPA_NUM_REF 16
`define FSPA_NUM_CHAN 8
`define FSPA_NUM_OUT 12
`define FSPA_REF_IDX_W 4
`define FSPA_CHAN_IDX_W 3
`define FSPA_DIV_W 16
`define FSPA_RATE_W 4
`define FSPA_WIDTH_SEL_W 2
`define FSPA_CNT_RST 16'h0000
`define FSPA_MIN_CLK_DIV 16'h0002
`define FSPA_MIN_FRAME_DIV 16'h0001
`define FSPA_PULSE_BASE 16'h0001

`endif

// ===== rtl/fspa_pkg.sv
// Types shared by the frame and sync pulse alignment block
package fspa_pkg;
  `include "fspa_regs.svh"

  // Supported frame or sync pulse rates
  typedef enum logic [`FSPA_RATE_W-1:0] {
    FSPA_RATE_PULSE_PER_EVEN_SECOND = 4'h0,
    FSPA_RATE_1PPS = 4'h1,
    FSPA_RATE_5PPS = 4'h2,
    FSPA_RATE_10PPS = 4'h3,
    FSPA_RATE_50HZ = 4'h4,
    FSPA_RATE_100HZ = 4'h5,
    FSPA_RATE_1KHZ = 4'h6,
    FSPA_RATE_2KHZ = 4'h7,
    FSPA_RATE_4KHZ = 4'h8,
    FSPA_RATE_8KHZ = 4'h9
  } fspa_rate_type;

  // Alignment sequencer states, one-hot
  typedef enum logic [1:0] {
    FSPA_ST_WAIT = 2'b01,
    FSPA_ST_ARM = 2'b10
  } fspa_state_type;

  // Per channel configuration
  typedef struct packed {
    logic [`FSPA_REF_IDX_W-1:0] clk_sel;
    logic [`FSPA_REF_IDX_W-1:0] pulse_sel;
    logic sync_mode;
    logic fall_edge;
    logic channel_pulse_align_enable;
    fspa_rate_type rate;
    logic [`FSPA_DIV_W-1:0] channel_master_divider;
    logic [`FSPA_DIV_W-1:0] frame_div;
    logic [`FSPA_WIDTH_SEL_W-1:0] width_sel;
  } fspa_chan_cfg_type;

  // Per output configuration
  typedef struct packed {
    logic [`FSPA_CHAN_IDX_W-1:0] chan;
    logic pulse_role;
  } fspa_out_cfg_type;

  // Per channel status
  typedef struct packed {
    logic armed;
    logic align_seen;
    logic phase_ok;
    logic rate_err;
  } fspa_chan_stat_type;
endpackage : fspa_pkg

// ===== rtl/fspa_sync.sv
// Two flip-flop synchroniser for the reference input pins
`include "fspa_regs.svh"
module fspa_sync
  import fspa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [`FSPA_NUM_REF-1:0] async_i,
  output logic [`FSPA_NUM_REF-1:0] sync_o
);

  logic [`FSPA_NUM_REF-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : fspa_sync

// ===== verification/fspa_assertions.sv
// Port checker for channel 0 of the pulse alignment block
`include "fspa_regs.svh"
module fspa_checker
  import fspa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire fspa_chan_cfg_type chan_cfg_i [`FSPA_NUM_CHAN],
  input wire fspa_out_cfg_type out_cfg_i [`FSPA_NUM_OUT],
  input wire logic [`FSPA_NUM_OUT-1:0] out_o,
  input wire fspa_chan_stat_type chan_stat_o [`FSPA_NUM_CHAN]
);
  // Short views of channel 0; arm_ok kept as a net so $past sees a signal
  wire fspa_chan_cfg_type c = chan_cfg_i[0];
  wire fspa_chan_stat_type s = chan_stat_o[0];
  wire arm_ok = !c.sync_mode && c.channel_pulse_align_enable;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_align; $rose(s.align_seen); endsequence
  property p_rst; $fell(rst_i) |-> out_o == '0 && s == '0; endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_rate; c.rate > 4'h9 |=> s.rate_err; endproperty
  a_rate: assert property (p_rate) else $error("rate_err not set");
  property p_off; !c.channel_pulse_align_enable |=> !s.align_seen; endproperty
  a_off: assert property (p_off) else $error("aligned while off");
  property p_arm; $rose(s.armed) |-> $past(arm_ok); endproperty
  a_arm: assert property (p_arm) else $error("armed outside frame mode");
  property p_sync; c.sync_mode |-> !s.armed; endproperty
  a_sync: assert property (p_sync) else $error("armed in sync mode");
  property p_fell; $fell(s.armed) |-> s.align_seen; endproperty
  a_fell: assert property (p_fell) else $error("arm left unaligned");
  property p_out; s_align ##0 c.frame_div > 16'h0001 |=> out_o[0] && out_o[1]; endproperty
  a_out: assert property (p_out) else $error("no output edge after alignment");
  property p_nopulse; c.frame_div < 16'h0002 |-> !out_o[1]; endproperty
  a_nopulse: assert property (p_nopulse) else $error("pulse with unit divider");
endmodule : fspa_checker

bind fspa_top fspa_checker u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .chan_cfg_i(chan_cfg_i),
  .out_cfg_i(out_cfg_i), .out_o(out_o), .chan_stat_o(chan_stat_o));

// ===== verification/fspa_remote_src.sv
// Remote source: free running reference clock and frame pulse
module fspa_remote_src (
  input wire logic [7:0] ratio_i,
  output logic ref_clk_o,
  output logic pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  // Pulse moves on falling reference edges, so it always leads a rising one
  initial begin
    ref_clk_o = 1'b0;
    pulse_o = 1'b0;
    #0.5;
    forever begin
      #111 ref_clk_o = 1'b1;
      #111 ref_clk_o = 1'b0;
      n = (n + 1) % ratio_i;
      pulse_o = n < 3;
    end
  end
endmodule : fspa_remote_src

// ===== verification/tb_fspa_top.sv
// Random trial bench for the pulse alignment block
module tb_fspa_top
  import fspa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] ref_in_i;
  fspa_chan_cfg_type cfg [8] = '{default: '0};
  fspa_out_cfg_type ocfg [12] = '{default: '0};
  logic [11:0] out_o;
  fspa_chan_stat_type stat [8];
  logic rclk, pls, pp, as_p, arm_seen, eq_bad;
  logic [7:0] ratio = 8'h04;
  int n_mismatch = 0, n_checks = 0, cyc = 0, t_edge, dv, fd;
  fspa_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ref_in_i(ref_in_i), .chan_cfg_i(cfg),
    .out_cfg_i(ocfg), .out_o(out_o), .chan_stat_o(stat));
  fspa_remote_src src (.ratio_i(ratio), .ref_clk_o(rclk), .pulse_o(pls));
  // Source on the two selected pins, the rest idle low
  always_comb begin
    ref_in_i = '0;
    ref_in_i[cfg[0].clk_sel] = rclk;
    ref_in_i[cfg[0].pulse_sel] = pls;
  end
  initial forever #25 core_clk_i = ~core_clk_i;
  function automatic int eff(logic [15:0] v, int lo);
    return v < lo ? lo : int'(v);
  endfunction : eff
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // Edge to alignment delay; a wrong pulse edge lands 13 cycles off
  always @(posedge core_clk_i) begin
    cyc++;
    if (rst_i) begin
      t_edge = -1;
      arm_seen = 1'b0;
      eq_bad = 1'b0;
    end else begin
      if (t_edge < 0 && pls != pp && pls != cfg[0].fall_edge) t_edge = cyc;
      if (stat[0].armed === 1'b1) arm_seen = 1'b1;
      if (stat[0].align_seen === 1'b1 && !as_p) chk("delay", 1, t_edge >= 0 && cyc - t_edge inside {[2:9]});
      foreach (ocfg[p]) if (out_o[p] !== out_o[ocfg[p].pulse_role]) eq_bad = 1'b1;
    end
    pp = pls;
    as_p = stat[0].align_seen === 1'b1;
  end
  // Twelve trials covering every mode, edge choice and rate code
  initial begin
    fspa_chan_cfg_type c;
    void'($urandom(81021));
    for (int t = 0; t < 12; t++) begin
      c.clk_sel = 4'($urandom);
      c.pulse_sel = c.clk_sel ^ 4'($urandom_range(15, 1));
      c.sync_mode = t[0];
      c.fall_edge = t[1];
      c.channel_pulse_align_enable = t % 5 != 4;
      c.rate = fspa_rate_type'(t == 11 ? 4'hc : 4'(t % 10));
      c.channel_master_divider = 16'($urandom_range(5));
      c.frame_div = 16'($urandom_range(4));
      c.width_sel = 2'($urandom);
      dv = eff(c.channel_master_divider, 2);
      fd = eff(c.frame_div, 1);
      @(posedge core_clk_i);
      rst_i <= 1'b1;
      @(posedge core_clk_i);
      ratio <= 8'(dv * fd * $urandom_range(3, 2));
      foreach (cfg[k]) cfg[k] <= c;
      foreach (ocfg[p]) ocfg[p] <= p < 2 ? fspa_out_cfg_type'({3'h0, p[0]}) : fspa_out_cfg_type'(4'($urandom));
      repeat (5) @(posedge core_clk_i);
      wait (pls);
      wait (!pls);
      repeat (4) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (16 * ratio) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk("align_seen", c.channel_pulse_align_enable, stat[0].align_seen);
      chk("armed_seen", c.channel_pulse_align_enable && !c.sync_mode, arm_seen);
      chk("phase_ok", c.channel_pulse_align_enable, stat[3].phase_ok);
      chk("rate_err", c.rate > 4'h9, stat[7].rate_err);
      chk("copies", 0, eq_bad);
    end
    end_sim();
  end
  // Watchdog well past the longest trial sequence
  initial begin
    repeat (40000) @(posedge core_clk_i);
    n_mismatch++;
    end_sim();
  end
endmodule : tb_fspa_top
